// ==== logic/mon_pkg.sv ====
// Shared constants, types and decode helpers for the monitor sequencer
package mon_pkg;
   // Register map, byte index on the register port
   localparam logic [7:0] READING_BASE = 8'h20;
   localparam logic [7:0] START_ADDR = 8'h40;
   localparam logic [7:0] STATUS1_ADDR = 8'h41;
   localparam logic [7:0] STATUS2_ADDR = 8'h42;
   localparam logic [7:0] EVENT_EN_ADDR = 8'h43;
   localparam logic [7:0] LIMIT_BASE = 8'h50;
   localparam logic [7:0] SFR_ADDR = 8'h7c;
   localparam logic [7:0] VOLT_EN_ADDR = 8'h7e;
   localparam logic [7:0] CONFIG_REGISTER_ADDR = 8'h7f;
   localparam logic [7:0] FAN_EN_ADDR = 8'h80;
   localparam logic [7:0] TEMP_EN_ADDR = 8'h82;
   // Field positions
   localparam int START_BIT = 0;
   localparam int MODE_BIT = 1;
   localparam int GEN_BIT = 2;
   localparam int AVG_LO = 5;
   localparam int SRST_BIT = 7;
   localparam int P2INT_BIT = 1;
   localparam int T3INT_BIT = 0;
   localparam int GRP_BIT = 0;
   // Reset values
   localparam logic [7:0] SFR_RST = 8'h40;
   localparam logic [7:0] LIMIT_RST = 8'hff;
   localparam logic [7:0] EN_RST = 8'h00;
   localparam logic [7:0] EVENT_EN_RST = 8'hff;
   // Input grouping: 0 remote1, 1 internal, 2 vcc, 3 +12, 4 +5, 5 +2.5, 6 core, 7 remote2
   localparam int NUM_IN = 8;
   localparam logic [7:0] TEMP_MASK = 8'h83;
   localparam logic [7:0] VOLT_MASK = 8'h7c;
   // Timing
   localparam int REF_CLK_HZ = 200_000_000;
   localparam int CONV_CLK_HZ = 45_000;
   localparam int TICK_CYCLES = REF_CLK_HZ / CONV_CLK_HZ;
   localparam logic [7:0] TEMP_TICKS = 8'd96;
   localparam logic [7:0] VOLT_TICKS = 8'd68;
   localparam int IDLE_SECONDS = 1;
   localparam int IDLE_TICKS = IDLE_SECONDS * CONV_CLK_HZ;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;

   typedef struct packed {
      logic start;
      logic [2:0] sel;
   } conv_req_t;

   typedef enum logic [1:0] {S_IDLE, S_CONV, S_COMMIT, S_REST} seq_state_t;

   // Temperature inputs use the longer conversion
   function automatic logic is_temp(input logic [2:0] idx);
      is_temp = TEMP_MASK[idx];
   endfunction

   // Averaging as a right shift; the top field bit wins
   function automatic logic [2:0] avg_shift(input logic [2:0] avg, input logic [2:0] idx);
      logic remote;
      remote = (idx == 3'd0) || (idx == 3'd7);
      if (avg[2]) begin
         avg_shift = 3'd5;
      end else if (avg[1]) begin
         avg_shift = 3'd4;
      end else if (avg[0]) begin
         avg_shift = remote ? 3'd4 : 3'd0;
      end else begin
         avg_shift = remote ? 3'd7 : 3'd3;
      end
   endfunction
endpackage

// ==== logic/monitor_conversion_sequencer.sv ====
// Conversion sequencer, limit checks, status and alert response logic
// Functional notes
// - Answer alert address only when enabled and pending
// - Pull alert low when enabled status set
// - Alert response byte carries own address
// - Acknowledged alert response clears global enable
// - Software re-enables; alert returns after the next sequence end
// - Answer alert address without pin routing
// - Start bit begins monitoring; readings readable
// - Compare readings to limits, record faults
// - Reset defaults all but reading registers
// - Config bit 7 soft reset, self clearing
// - Mode bit selects continuous or cycling
// - 45 kHz clock; 96/68 clocks per conversion
// - Averaging field priority decoded, top wins
// - Averaging counts per field; update after average
// - Averaging field resets to 010
// - Fixed eight input conversion order
// - Cycling idles one second; continuous loops
// - Status sticky until read and inactive
//
// Design decisions made here: the plain strobed port and the address map.
module monitor_conversion_sequencer #(
   parameter int TICK_CYC = mon_pkg::TICK_CYCLES,
   parameter int IDLE_TK = mon_pkg::IDLE_TICKS
) (
   input wire logic ref_clk, // 200 MHz clock
   input wire logic rstn, // Synchronous reset, active low
   input wire mon_pkg::bus_req_t bus_req, // Register port request
   output logic [7:0] rdata, // Read data, cycle after read strobe
   output mon_pkg::conv_req_t conv_req, // Converter start pulse and input select
   input wire logic conv_done, // Converter result valid pulse
   input wire logic [7:0] conv_data, // Converter result
   input wire logic [1:0] diode_fault, // Remote diode fault levels
   input wire logic [6:0] slave_addr, // Own bus address
   input wire logic ara_req, // Alert response address seen, pulse
   output logic ara_ack, // Acknowledge alert response address
   output logic [7:0] ara_data, // Alert response byte
   output logic alert_pull_n, // Alert pull-down request, active low
   output logic fan_drive_pin_two_alert_oe, // Alert driven on fan drive pin two
   output logic speed_sense_pin_three_alert_oe // Alert driven on speed sense pin three
);
   import mon_pkg::*;

   logic [7:0] reading_ff [NUM_IN];
   logic [7:0] nxt_reading [NUM_IN];
   logic [7:0] limit_ff [NUM_IN];
   logic [7:0] nxt_limit [NUM_IN];
   logic [7:0] status1_ff, nxt_status1, status_set, over;
   logic [1:0] status2_ff, nxt_status2, fault_set;
   logic [7:0] event_en_ff, nxt_event_en, sfr_ff, nxt_sfr, config_register_ff, nxt_config_register;
   logic [7:0] volt_en_ff, nxt_volt_en, fan_en_ff, nxt_fan_en, temp_en_ff, nxt_temp_en;
   logic start_ff, nxt_start, srst_ff, nxt_srst, arm_ff, nxt_arm, clr;
   logic [7:0] rdata_ff, nxt_rdata, ara_data_ff, nxt_ara_data, pending;
   logic ara_take, rd_s1, rd_s2, seq_end, commit, tick;
   seq_state_t state_ff, nxt_state;
   logic [2:0] idx_ff, nxt_idx;
   logic [7:0] tk_ff, nxt_tk, samp_ff, nxt_samp;
   logic [15:0] acc_ff, nxt_acc, avg_val;
   logic [16:0] idle_ff, nxt_idle;
   logic [15:0] div_ff, nxt_div;
   logic done_ff, nxt_done;
   conv_req_t conv_ff, nxt_conv;

   // Power-on or soft reset; reading registers are not cleared
   assign clr = !rstn || srst_ff;
   assign rd_s1 = bus_req.rd && (bus_req.addr == STATUS1_ADDR);
   assign rd_s2 = bus_req.rd && (bus_req.addr == STATUS2_ADDR);
   assign pending = status1_ff & ((TEMP_MASK & {8{temp_en_ff[GRP_BIT]}})
                                | (VOLT_MASK & {8{volt_en_ff[GRP_BIT]}}));
   // Acknowledge needs global enable and a group-enabled status bit
   assign ara_ack = sfr_ff[GEN_BIT] && (|pending);
   assign ara_take = ara_req && ara_ack;
   assign ara_data = ara_data_ff;
   assign rdata = rdata_ff;
   assign conv_req = conv_ff;
   // Pull-down waits for re-arm at the end of a sequence
   assign alert_pull_n = !(ara_ack && arm_ff);
   assign fan_drive_pin_two_alert_oe = !alert_pull_n && config_register_ff[P2INT_BIT];
   assign speed_sense_pin_three_alert_oe = !alert_pull_n && config_register_ff[T3INT_BIT];
   assign commit = (state_ff == S_COMMIT);
   assign seq_end = commit && (idx_ff == 3'(NUM_IN - 1));
   assign avg_val = acc_ff >> avg_shift(sfr_ff[7:AVG_LO], idx_ff);

   // Limit comparison, equal counts as a violation
   always_comb begin
      for (int i = 0; i < NUM_IN; i++) begin
         over[i] = reading_ff[i] >= limit_ff[i];
      end
   end

   // Register file next values
   always_comb begin
      nxt_limit = limit_ff;
      nxt_start = start_ff;
      nxt_sfr = sfr_ff;
      nxt_config_register = config_register_ff;
      nxt_event_en = event_en_ff;
      nxt_volt_en = volt_en_ff;
      nxt_fan_en = fan_en_ff;
      nxt_temp_en = temp_en_ff;
      nxt_srst = 1'b0;
      nxt_arm = arm_ff;
      nxt_ara_data = ara_data_ff;
      status_set = 8'h00;
      fault_set = 2'b00;
      if (commit && event_en_ff[idx_ff] && (avg_val[7:0] >= limit_ff[idx_ff])) begin
         status_set[idx_ff] = 1'b1;
      end
      if (commit && (idx_ff == 3'd0)) begin
         fault_set[0] = diode_fault[0];
      end
      if (commit && (idx_ff == 3'd7)) begin
         fault_set[1] = diode_fault[1];
      end
      // Read clears only inactive bits; a set in the same cycle wins
      nxt_status1 = (status1_ff & ~({8{rd_s1}} & ~over)) | status_set;
      nxt_status2 = (status2_ff & ~({2{rd_s2}} & ~diode_fault)) | fault_set;
      if (bus_req.wr) begin
         if (bus_req.addr == START_ADDR) begin
            nxt_start = bus_req.wdata[START_BIT];
         end else if (bus_req.addr == SFR_ADDR) begin
            nxt_sfr = bus_req.wdata;
         end else if (bus_req.addr == CONFIG_REGISTER_ADDR) begin
            nxt_config_register = {1'b0, bus_req.wdata[6:0]};
            nxt_srst = bus_req.wdata[SRST_BIT];
         end else if (bus_req.addr == EVENT_EN_ADDR) begin
            nxt_event_en = bus_req.wdata;
         end else if (bus_req.addr == VOLT_EN_ADDR) begin
            nxt_volt_en = bus_req.wdata;
         end else if (bus_req.addr == FAN_EN_ADDR) begin
            nxt_fan_en = bus_req.wdata;
         end else if (bus_req.addr == TEMP_EN_ADDR) begin
            nxt_temp_en = bus_req.wdata;
         end else if (bus_req.addr[7:3] == LIMIT_BASE[7:3]) begin
            nxt_limit[bus_req.addr[2:0]] = bus_req.wdata;
         end
      end
      // Alert response: give address, drop global enable, disarm
      if (ara_take) begin
         nxt_ara_data = {slave_addr, 1'b1};
         nxt_sfr[GEN_BIT] = 1'b0;
         nxt_arm = 1'b0;
      end else if (seq_end) begin
         nxt_arm = 1'b1;
      end
      // Read data, undefined addresses read zero
      nxt_rdata = 8'h00;
      if (bus_req.rd) begin
         if (bus_req.addr == START_ADDR) begin
            nxt_rdata = {7'h00, start_ff};
         end else if (bus_req.addr == STATUS1_ADDR) begin
            nxt_rdata = status1_ff;
         end else if (bus_req.addr == STATUS2_ADDR) begin
            nxt_rdata = {6'h00, status2_ff};
         end else if (bus_req.addr == EVENT_EN_ADDR) begin
            nxt_rdata = event_en_ff;
         end else if (bus_req.addr == SFR_ADDR) begin
            nxt_rdata = sfr_ff;
         end else if (bus_req.addr == CONFIG_REGISTER_ADDR) begin
            nxt_rdata = config_register_ff;
         end else if (bus_req.addr == VOLT_EN_ADDR) begin
            nxt_rdata = volt_en_ff;
         end else if (bus_req.addr == FAN_EN_ADDR) begin
            nxt_rdata = fan_en_ff;
         end else if (bus_req.addr == TEMP_EN_ADDR) begin
            nxt_rdata = temp_en_ff;
         end else if (bus_req.addr[7:3] == LIMIT_BASE[7:3]) begin
            nxt_rdata = limit_ff[bus_req.addr[2:0]];
         end else if (bus_req.addr[7:3] == READING_BASE[7:3]) begin
            nxt_rdata = reading_ff[bus_req.addr[2:0]];
         end
      end
   end

   // Register file storage
   always_ff @(posedge ref_clk) begin
      rdata_ff <= nxt_rdata;
      if (!rstn) begin
         rdata_ff <= 8'h00;
      end
      if (clr) begin
         for (int i = 0; i < NUM_IN; i++) begin
            limit_ff[i] <= LIMIT_RST;
         end
         start_ff <= 1'b0;
         sfr_ff <= SFR_RST;
         config_register_ff <= EN_RST;
         event_en_ff <= EVENT_EN_RST;
         volt_en_ff <= EN_RST;
         fan_en_ff <= EN_RST;
         temp_en_ff <= EN_RST;
         status1_ff <= 8'h00;
         status2_ff <= 2'b00;
         srst_ff <= 1'b0;
         arm_ff <= 1'b1;
         ara_data_ff <= 8'h00;
      end else begin
         limit_ff <= nxt_limit;
         start_ff <= nxt_start;
         sfr_ff <= nxt_sfr;
         config_register_ff <= nxt_config_register;
         event_en_ff <= nxt_event_en;
         volt_en_ff <= nxt_volt_en;
         fan_en_ff <= nxt_fan_en;
         temp_en_ff <= nxt_temp_en;
         status1_ff <= nxt_status1;
         status2_ff <= nxt_status2;
         srst_ff <= nxt_srst;
         arm_ff <= nxt_arm;
         ara_data_ff <= nxt_ara_data;
      end
   end

   // Conversion clock tick from the reference clock
   assign tick = (div_ff == 16'(TICK_CYC - 1));

   // Sequencer next values
   always_comb begin
      nxt_state = state_ff;
      nxt_idx = idx_ff;
      nxt_tk = tk_ff;
      nxt_samp = samp_ff;
      nxt_acc = acc_ff;
      nxt_idle = idle_ff;
      nxt_done = done_ff || conv_done;
      nxt_conv = '{start: 1'b0, sel: idx_ff};
      nxt_div = tick ? 16'h0000 : div_ff + 16'h0001;
      nxt_reading = reading_ff;
      case (state_ff)
         S_IDLE: begin
            nxt_idx = 3'd0;
            if (start_ff) begin
               nxt_state = S_CONV;
               nxt_conv = '{start: 1'b1, sel: 3'd0};
               nxt_tk = 8'h00;
               nxt_samp = 8'h00;
               nxt_acc = 16'h0000;
               nxt_done = 1'b0;
            end
         end
         S_CONV: begin
            if (tick) begin
               nxt_tk = tk_ff + 8'h01;
            end
            // Conversion closes after its full tick count and the done pulse
            if (tick && (tk_ff >= (is_temp(idx_ff) ? TEMP_TICKS : VOLT_TICKS) - 8'h01)
                && (done_ff || conv_done)) begin
               nxt_acc = acc_ff + {8'h00, conv_data};
               nxt_tk = 8'h00;
               nxt_done = 1'b0;
               nxt_samp = samp_ff + 8'h01;
               if (samp_ff == 8'((9'h001 << avg_shift(sfr_ff[7:AVG_LO], idx_ff)) - 9'h001)) begin
                  nxt_state = S_COMMIT;
               end else begin
                  nxt_conv = '{start: 1'b1, sel: idx_ff};
               end
            end
         end
         S_COMMIT: begin
            nxt_reading[idx_ff] = avg_val[7:0];
            nxt_idx = idx_ff + 3'd1;
            nxt_tk = 8'h00;
            nxt_samp = 8'h00;
            nxt_acc = 16'h0000;
            nxt_done = 1'b0;
            nxt_idle = 17'h00000;
            if (!start_ff) begin
               nxt_state = S_IDLE;
            end else if (seq_end && sfr_ff[MODE_BIT]) begin
               nxt_state = S_REST;
            end else begin
               nxt_state = S_CONV;
               nxt_conv = '{start: 1'b1, sel: nxt_idx};
            end
         end
         S_REST: begin
            if (tick) begin
               nxt_idle = idle_ff + 17'h00001;
            end
            if (!start_ff) begin
               nxt_state = S_IDLE;
            end else if (tick && (idle_ff == 17'(IDLE_TK - 1))) begin
               nxt_state = S_CONV;
               nxt_conv = '{start: 1'b1, sel: 3'd0};
               nxt_done = 1'b0;
            end
         end
         default: nxt_state = S_IDLE;
      endcase
   end

   // Sequencer storage; readings keep their contents through any reset
   always_ff @(posedge ref_clk) begin
      reading_ff <= nxt_reading;
      if (clr) begin
         state_ff <= S_IDLE;
         idx_ff <= 3'd0;
         tk_ff <= 8'h00;
         samp_ff <= 8'h00;
         acc_ff <= 16'h0000;
         idle_ff <= 17'h00000;
         done_ff <= 1'b0;
         conv_ff <= '{start: 1'b0, sel: 3'd0};
         div_ff <= 16'h0000;
      end else begin
         state_ff <= nxt_state;
         idx_ff <= nxt_idx;
         tk_ff <= nxt_tk;
         samp_ff <= nxt_samp;
         acc_ff <= nxt_acc;
         idle_ff <= nxt_idle;
         done_ff <= nxt_done;
         conv_ff <= nxt_conv;
         div_ff <= nxt_div;
      end
   end

   // Checks on the block's own behaviour
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   sequence soft_reset_seq;
      srst_ff ##1 (sfr_ff == SFR_RST && start_ff == 1'b0);
   endsequence

   a_ara_ack_gate: assert property (ara_ack |-> sfr_ff[GEN_BIT] && (|pending))
      else $error("alert response acknowledged without enable or pending event");
   a_alert_cause: assert property (!alert_pull_n |-> ara_ack && arm_ff)
      else $error("alert pulled without cause");
   a_ara_byte: assert property (ara_take && !srst_ff |=> ara_data[7:1] == $past(slave_addr))
      else $error("alert response byte lacks own address");
   a_ara_gen_clear: assert property (ara_take && !srst_ff |=> !sfr_ff[GEN_BIT] && alert_pull_n)
      else $error("global enable not cleared after alert response");
   a_alert_rearm: assert property (ara_take && !srst_ff |=> !arm_ff throughout (!seq_end)[*2])
      else $error("alert rearmed before end of sequence");
   a_start_gate: assert property (conv_req.start |-> $past(start_ff))
      else $error("conversion started without start bit");
   a_srst_self: assert property (bus_req.wr && bus_req.addr == CONFIG_REGISTER_ADDR
      && bus_req.wdata[SRST_BIT] |=> soft_reset_seq)
      else $error("soft reset did not restore defaults");
   a_conv_spacing: assert property (conv_req.start |=> !conv_req.start [*8])
      else $error("conversion restarted too soon");
   a_status_set: assert property (commit && !srst_ff && |status_set |=> |status1_ff)
      else $error("limit violation not recorded");
   a_status_wr_ignored: assert property (bus_req.wr && bus_req.addr == STATUS1_ADDR
      && !commit && !rd_s1 && !srst_ff |=> status1_ff == $past(status1_ff))
      else $error("status register changed by a write");
endmodule

// ==== sim/conv_model.sv ====
// Behavioural analog converter that answers the sequencer's start/done handshake
module conv_model
   import mon_pkg::*;
#(
   parameter int DLY = 7
) (
   input wire logic ref_clk, // 200 MHz clock
   input wire mon_pkg::conv_req_t conv_req, // Start pulse and input select
   input wire logic [63:0] val_tab, // Result per input, byte i for input i
   output logic conv_done, // Result valid pulse
   output logic [7:0] conv_data // Result, garbage until the sample is done
);
   int wait_cnt = 0;
   logic have_val = 1'b0;
   logic [7:0] val = 8'h00;
   initial conv_done = 1'b0;
   // Answer each start after a fixed delay with the selected input's value
   always @(posedge ref_clk) begin
      conv_done <= 1'b0;
      if (conv_req.start) begin
         wait_cnt <= DLY;
         have_val <= 1'b0;
         val <= val_tab[{conv_req.sel, 3'b000} +: 8];
      end else if (wait_cnt == 1) begin
         conv_done <= 1'b1;
         have_val <= 1'b1;
         wait_cnt <= 0;
      end else if (wait_cnt > 1) begin
         wait_cnt <= wait_cnt - 1;
      end
   end
   // Inverted value until done, so an early sample never looks right
   assign conv_data = have_val ? val : ~val;
endmodule

// ==== sim/monitor_conversion_sequencer_bench.sv ====
// Self-checking bench for the monitor conversion sequencer
module monitor_conversion_sequencer_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import mon_pkg::*;
   localparam int TK = 2;
   localparam int IDL = 20;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   bus_req_t bus_req = '0;
   logic [7:0] rdata;
   conv_req_t conv_req;
   logic conv_done;
   logic [7:0] conv_data;
   logic [1:0] diode_fault = 2'b00;
   logic [6:0] slave_addr = 7'h2e;
   logic ara_req = 1'b0;
   logic ara_ack, alert_pull_n, p2_oe, t3_oe;
   logic [7:0] ara_data;
   logic [63:0] val_tab = 64'h8776655443322110;
   int fails = 0, tests_run = 0, cyc = 0, seqs = 0, chg = 0, nst = 0, run = 0, prev_cyc = 0;
   logic [2:0] prev_sel = 3'h0;
   int cnt[8];
   int gap[8];

   always #2.5 ref_clk = ~ref_clk;

   monitor_conversion_sequencer #(.TICK_CYC(TK), .IDLE_TK(IDL)) dut_u (
      .ref_clk(ref_clk), .rstn(rstn), .bus_req(bus_req), .rdata(rdata),
      .conv_req(conv_req), .conv_done(conv_done), .conv_data(conv_data),
      .diode_fault(diode_fault), .slave_addr(slave_addr), .ara_req(ara_req),
      .ara_ack(ara_ack), .ara_data(ara_data), .alert_pull_n(alert_pull_n),
      .fan_drive_pin_two_alert_oe(p2_oe), .speed_sense_pin_three_alert_oe(t3_oe));

   conv_model conv_u (.ref_clk(ref_clk), .conv_req(conv_req), .val_tab(val_tab),
      .conv_done(conv_done), .conv_data(conv_data));

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic finish_test();
      $display("Checks run %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Watch converter starts: order, samples per input, spacing; cut a hang short
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 90000) begin
         fails++;
         finish_test();
      end
      if (rstn && conv_req.start === 1'b1) begin
         nst++;
         if (run == 0) begin
            chk("first input", 16'h0, 16'(conv_req.sel));
         end else if (conv_req.sel != prev_sel) begin
            chk("input order", 16'(3'(prev_sel + 3'd1)), 16'(conv_req.sel));
            cnt[prev_sel] = run;
            gap[conv_req.sel] = cyc - prev_cyc;
            run = 0;
            chg++;
            if (prev_sel == 3'd7) begin
               seqs++;
            end
         end
         prev_sel = conv_req.sel;
         prev_cyc = cyc;
         run++;
      end
   end

   task automatic wait_ge(ref int v, input int t);
      for (int k = 0; k < 40000 && v < t; k++) @(posedge ref_clk);
      #1;
      chk("progress", 16'h1, 16'(v >= t));
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      bus_req <= '{a, d, 1'b1, 1'b0};
      @(posedge ref_clk);
      bus_req <= '0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
      @(posedge ref_clk);
      bus_req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge ref_clk);
      bus_req <= '0;
      #1;
      chk(nm, 16'(exp), 16'(rdata));
   endtask

   task automatic t_reset();
      repeat (50) @(posedge ref_clk);
      #1;
      chk("starts before start bit", 16'h0, 16'(nst));
      chk("alert idle", 16'h1, 16'(alert_pull_n));
      chk("ack idle", 16'h0, 16'(ara_ack));
      rd(SFR_ADDR, SFR_RST, "sfr default");
      rd(EVENT_EN_ADDR, EVENT_EN_RST, "event enable default");
      rd(LIMIT_BASE + 8'h3, LIMIT_RST, "limit default");
      rd(VOLT_EN_ADDR, EN_RST, "group enable default");
      rd(STATUS1_ADDR, 8'h00, "status default");
      rd(8'h30, 8'h00, "unmapped read");
   endtask

   task automatic t_prio();
      wr(SFR_ADDR, 8'ha0);
      wr(START_ADDR, 8'h01);
      wait_ge(chg, 1);
      chk("samples with top bit", 16'd32, 16'(cnt[0]));
   endtask

   task automatic t_soft();
      wr(CONFIG_REGISTER_ADDR, 8'h80);
      @(posedge ref_clk);
      rd(SFR_ADDR, SFR_RST, "sfr after soft reset");
      rd(CONFIG_REGISTER_ADDR, 8'h00, "config_register self clear");
      rd(START_ADDR, 8'h00, "start after soft reset");
      repeat (400) @(posedge ref_clk);
      run = 0;
   endtask

   task automatic t_alert();
      wr(LIMIT_BASE + 8'h2, 8'h30);
      wr(VOLT_EN_ADDR, 8'h01);
      wr(SFR_ADDR, 8'h20);
      wr(START_ADDR, 8'h01);
      wait_ge(seqs, seqs + 1);
      for (int i = 0; i < 8; i++) begin
         rd(READING_BASE + 8'(i), val_tab[i * 8 +: 8], "reading");
         chk("samples", 16'((i == 0 || i == 7) ? 16 : 1), 16'(cnt[i]));
      end
      rd(STATUS1_ADDR, 8'h04, "status over limit");
      chk("ack without enable", 16'h0, 16'(ara_ack));
      chk("alert without enable", 16'h1, 16'(alert_pull_n));
      wr(SFR_ADDR, 8'h24);
      #1;
      chk("ack enabled", 16'h1, 16'(ara_ack));
      chk("alert enabled", 16'h0, 16'(alert_pull_n));
      for (int c = 3; c >= 0; c--) begin
         wr(CONFIG_REGISTER_ADDR, 8'(c));
         #1;
         chk("pin two drive", 16'(c[1]), 16'(p2_oe));
         chk("pin three drive", 16'(c[0]), 16'(t3_oe));
      end
      chk("ack without pin", 16'h1, 16'(ara_ack));
      @(posedge ref_clk);
      ara_req <= 1'b1;
      @(posedge ref_clk);
      ara_req <= 1'b0;
      #1;
      chk("response byte", 16'({slave_addr, 1'b1}), 16'(ara_data));
      chk("ack after response", 16'h0, 16'(ara_ack));
      chk("alert after response", 16'h1, 16'(alert_pull_n));
      rd(SFR_ADDR, 8'h20, "enable cleared");
      wr(SFR_ADDR, 8'h24);
      #1;
      chk("alert held off", 16'h1, 16'(alert_pull_n));
      wait_ge(seqs, seqs + 2);
      chk("alert rearmed", 16'h0, 16'(alert_pull_n));
   endtask

   task automatic t_sticky();
      wr(LIMIT_BASE + 8'h2, 8'hff);
      diode_fault <= 2'b01;
      wait_ge(seqs, seqs + 2);
      rd(STATUS1_ADDR, 8'h04, "status sticky");
      rd(STATUS1_ADDR, 8'h00, "status cleared by read");
      rd(STATUS2_ADDR, 8'h01, "diode fault");
      wr(STATUS1_ADDR, 8'hff);
      rd(STATUS1_ADDR, 8'h00, "status write ignored");
      chk("alert released", 16'h1, 16'(alert_pull_n));
      chk("ack released", 16'h0, 16'(ara_ack));
   endtask

   task automatic t_mode();
      int g;
      diode_fault <= 2'b00;
      g = gap[0] - gap[2];
      chk("continuous loop", 16'h1, 16'(g >= -TK && g <= TK));
      wr(SFR_ADDR, 8'h22);
      wait_ge(seqs, seqs + 2);
      g = gap[0] - gap[2];
      chk("cycling rest", 16'h1, 16'(g >= IDL * TK - TK && g <= IDL * TK + 3 * TK));
   endtask

   initial begin
      repeat (10) @(posedge ref_clk);
      rstn <= 1'b1;
      t_reset();
      t_prio();
      t_soft();
      t_alert();
      t_sticky();
      t_mode();
      finish_test();
   end
endmodule
